// *** core/tlp_pkg.sv ***
package tlp_pkg;
  // ==========================================================
  // Clocking and timing
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int LINK_SETTLE_NS = 16;
  localparam int LINK_SETTLE_CYC = (LINK_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] SETTLE_LOAD = 4'(LINK_SETTLE_CYC - 1);

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_BEAT_COUNT = 8'h10;

  // ==========================================================
  // Control fields and reset values
  localparam int CTRL_W = 5;
  localparam int CTRL_CORR_EN = 0;
  localparam int CTRL_NONFATAL_EN = 1;
  localparam int CTRL_FATAL_EN = 2;
  localparam int CTRL_UR_EN = 3;
  localparam int CTRL_ROM_EN = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // ==========================================================
  // Device error flag positions
  localparam int FLAG_CORR = 0;
  localparam int FLAG_NONFATAL = 1;
  localparam int FLAG_FATAL = 2;
  localparam int FLAG_UR = 3;

  // ==========================================================
  // Status register fields
  localparam int STAT_LINK_UP = 0;
  localparam int STAT_IN_FRAME = 1;
  localparam int STAT_OUT_VALID = 2;
  localparam int STAT_FLAGS_LSB = 4;

  // ==========================================================
  // Interrupt events
  localparam int IRQ_W = 5;
  localparam int IRQ_LINK_UP = 0;
  localparam int IRQ_LINK_DOWN = 1;
  localparam int IRQ_FATAL = 2;
  localparam int IRQ_FRAME_ERR = 3;
  localparam int IRQ_ERR_MSG = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    LINK_DOWN = 2'b00,
    LINK_TRAIN = 2'b01,
    LINK_UP = 2'b10
  } link_state_t;

  typedef enum logic [2:0] {
    KIND_CFG = 3'b000,
    KIND_ROM = 3'b001,
    KIND_MSG = 3'b010,
    KIND_MEMIO = 3'b011,
    KIND_CPL = 3'b100
  } rx_kind_t;

  typedef enum logic [1:0] {
    MSG_CORR = 2'b00,
    MSG_NONFATAL = 2'b01,
    MSG_FATAL = 2'b10
  } err_msg_t;
endpackage

// *** core/err_if.sv ***
`timescale 1ns/1ps
interface err_if;
  import tlp_pkg::*;
  logic corr_ev;
  logic nonfatal_ev;
  logic fatal_ev;
  logic ur_ev;
  logic [3:0] report_en;
  logic [3:0] clear;
  logic [3:0] flags;
  logic msg_valid;
  err_msg_t msg_kind;

  modport core (output corr_ev, nonfatal_ev, fatal_ev, ur_ev, report_en, clear,
                input flags, msg_valid, msg_kind);
  modport tracker (input corr_ev, nonfatal_ev, fatal_ev, ur_ev, report_en, clear,
                   output flags, msg_valid, msg_kind);
endinterface

// *** core/err_track.sv ***
`timescale 1ns/1ps
module err_track
  import tlp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Error events
  err_if.tracker err
);
  import tlp_pkg::*;

  logic [3:0] ev;
  assign ev = {err.ur_ev, err.fatal_ev, err.nonfatal_ev, err.corr_ev};

  // ==========================================================
  // Sticky flags, a new event beats a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err.flags <= 4'h0;
    end else begin
      err.flags <= (err.flags & ~err.clear) | ev;
    end
  end

  // ==========================================================
  // Upstream messages, most severe first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err.msg_valid <= 1'b0;
      err.msg_kind <= MSG_CORR;
    end else begin
      err.msg_valid <= |(ev & err.report_en);
      if (err.fatal_ev && err.report_en[FLAG_FATAL]) begin
        err.msg_kind <= MSG_FATAL;
      end else if ((err.nonfatal_ev && err.report_en[FLAG_NONFATAL]) ||
                   (err.ur_ev && err.report_en[FLAG_UR])) begin
        err.msg_kind <= MSG_NONFATAL;
      end else begin
        err.msg_kind <= MSG_CORR;
      end
    end
  end

  a_msg_gated: assert property (@(posedge clock) disable iff (!rst_n)
    err.msg_valid |-> |($past(ev) & $past(err.report_en)))
    else $error("error message sent while reporting disabled");
  a_fatal_flag: assert property (@(posedge clock) disable iff (!rst_n)
    err.fatal_ev |=> err.flags[FLAG_FATAL])
    else $error("fatal event did not set the fatal flag");
  a_fatal_msg: assert property (@(posedge clock) disable iff (!rst_n)
    (err.fatal_ev && err.report_en[FLAG_FATAL]) |=> err.msg_valid && err.msg_kind == MSG_FATAL)
    else $error("enabled fatal event sent no fatal message");
endmodule

// *** core/tlp_tx_stream.sv ***
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - Link-up output goes low only when device and partner can exchange packets.
// - Link-up stays high during training and rises on channel errors.
// - Hot reset or link disable drops link-up and discards held packets.
// - Remainder is sampled only when end, source-ready and destination-ready coincide.
// - Remainder 0 means full word valid; 1 means only bits 63:32 valid.
// - Destination-ready asserted only when the device can take a word.
// - One beat moves exactly when both ready signals are asserted together.
// - Four-bit error flags: correctable, non-fatal, fatal, unsupported request.
// - Error messages go upstream only when their reporting enable is set.
// - Training, link protocol, flow control, malformed or overflow events flag fatal.
// - Flags never reflect errors caused by the device's own transmit traffic.
// - Configuration requests are answered internally, never passed to the application.
// - ROM (if enabled), messages, BAR hits and completions go to the application.
module tlp_tx_stream
  import tlp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq,
  // Transmit stream from the application
  input wire logic [63:0] tx_word,
  input wire logic tx_sof_n,
  input wire logic tx_eof_n,
  input wire logic tx_rem_n,
  input wire logic tx_src_rdy_n,
  output logic tx_dst_rdy_n,
  // Link side of the transmit stream
  output logic [63:0] link_word,
  output logic link_sof,
  output logic link_eof,
  output logic link_upper_only,
  output logic link_valid,
  input wire logic link_ready,
  // Link state
  input wire logic partner_ready,
  input wire logic channel_error,
  input wire logic hot_reset,
  input wire logic link_disable,
  output logic link_up_n,
  // Receive-side error events
  input wire logic training_error,
  input wire logic link_protocol_error,
  input wire logic flow_control_error,
  input wire logic malformed_packet,
  input wire logic receiver_overflow,
  input wire logic correctable_error,
  input wire logic nonfatal_error,
  output logic [3:0] device_error_flags,
  output logic err_msg_valid,
  output tlp_pkg::err_msg_t err_msg_kind,
  // Inbound request routing
  input wire logic rx_valid,
  input wire tlp_pkg::rx_kind_t rx_kind,
  output logic cfg_answer_valid,
  output logic app_req_valid,
  output tlp_pkg::rx_kind_t app_req_kind
);
  import tlp_pkg::*;

  link_state_t link_q;
  logic [3:0] settle_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [IRQ_W-1:0] int_status_q;
  logic [IRQ_W-1:0] int_mask_q;
  logic [15:0] beat_count_q;
  logic in_frame_q;
  logic ack_q;
  logic flush;
  logic drop;
  logic beat;
  logic frame_err;
  logic wr;
  logic rd;
  logic [IRQ_W-1:0] int_set;
  logic ur_ev;
  logic fatal_ev;

  err_if err ();

  err_track u_err_track (
    .clock(clock),
    .rst_n(rst_n),
    .err(err.tracker)
  );

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction

  // ==========================================================
  // Link state
  assign flush = hot_reset || link_disable;
  assign drop = flush || channel_error || !partner_ready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= LINK_DOWN;
      settle_q <= 4'h0;
    end else begin
      case (link_q)
        LINK_DOWN: begin
          if (!flush && partner_ready) begin
            link_q <= LINK_TRAIN;
            settle_q <= SETTLE_LOAD;
          end
        end
        LINK_TRAIN: begin
          if (drop) begin
            link_q <= LINK_DOWN;
          end else if (settle_q == 4'h0) begin
            link_q <= LINK_UP;
          end else begin
            settle_q <= settle_q - 4'h1;
          end
        end
        LINK_UP: begin
          if (drop) begin
            link_q <= LINK_DOWN;
          end
        end
        default: link_q <= LINK_DOWN;
      endcase
    end
  end

  assign link_up_n = (link_q != LINK_UP);

  // ==========================================================
  // Transmit handshake, one holding stage toward the link
  assign tx_dst_rdy_n = !(!link_up_n && !flush && (!link_valid || link_ready));
  assign beat = !tx_src_rdy_n && !tx_dst_rdy_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_valid <= 1'b0;
      link_word <= 64'h0;
      link_sof <= 1'b0;
      link_eof <= 1'b0;
      link_upper_only <= 1'b0;
    end else if (flush || link_up_n) begin
      link_valid <= 1'b0;
    end else if (beat) begin
      link_valid <= 1'b1;
      link_word <= tx_word;
      link_sof <= !tx_sof_n;
      link_eof <= !tx_eof_n;
      link_upper_only <= !tx_eof_n && tx_rem_n;
    end else if (link_ready) begin
      link_valid <= 1'b0;
    end
  end

  // Framing check; it only raises an interrupt, never a device flag
  assign frame_err = beat && ((!tx_sof_n && in_frame_q) || (tx_sof_n && !in_frame_q));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_q <= 1'b0;
    end else if (flush || link_up_n) begin
      in_frame_q <= 1'b0;
    end else if (beat) begin
      in_frame_q <= tx_eof_n;
    end
  end

  // ==========================================================
  // Inbound routing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_answer_valid <= 1'b0;
      app_req_valid <= 1'b0;
      app_req_kind <= KIND_CFG;
    end else begin
      cfg_answer_valid <= rx_valid && rx_kind == KIND_CFG;
      app_req_valid <= 1'b0;
      if (rx_valid) begin
        case (rx_kind)
          KIND_ROM: app_req_valid <= ctrl_q[CTRL_ROM_EN];
          KIND_MSG, KIND_MEMIO, KIND_CPL: app_req_valid <= 1'b1;
          default: app_req_valid <= 1'b0;
        endcase
        app_req_kind <= rx_kind;
      end
    end
  end

  // Disabled ROM or unknown kinds get no forwarding and count as unsupported
  assign ur_ev = rx_valid && ((rx_kind == KIND_ROM && !ctrl_q[CTRL_ROM_EN]) ||
                 !(rx_kind inside {KIND_CFG, KIND_ROM, KIND_MSG, KIND_MEMIO, KIND_CPL}));
  assign fatal_ev = training_error || link_protocol_error || flow_control_error ||
                    malformed_packet || receiver_overflow;

  // ==========================================================
  // Error tracker hookup
  assign err.corr_ev = correctable_error;
  assign err.nonfatal_ev = nonfatal_error;
  assign err.fatal_ev = fatal_ev;
  assign err.ur_ev = ur_ev;
  assign err.report_en = ctrl_q[3:0];
  assign err.clear = (wr && reg_hit(adr_i, REG_STATUS) && sel_i[0]) ?
                     dat_i[STAT_FLAGS_LSB +: 4] : 4'h0;
  assign device_error_flags = err.flags;
  assign err_msg_valid = err.msg_valid;
  assign err_msg_kind = err.msg_kind;

  // ==========================================================
  // Wishbone registers, ack one cycle after the strobe; writes land on the ack edge
  assign wr = cyc_i && stb_i && we_i && ack_q;
  assign rd = cyc_i && stb_i && !we_i && !ack_q;
  assign ack_o = ack_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      int_mask_q <= IRQ_RESET;
    end else if (wr && sel_i[0]) begin
      if (reg_hit(adr_i, REG_CTRL)) begin
        ctrl_q <= dat_i[CTRL_W-1:0];
      end
      if (reg_hit(adr_i, REG_INT_MASK)) begin
        int_mask_q <= dat_i[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 32'h0;
    end else if (rd) begin
      if (reg_hit(adr_i, REG_CTRL)) begin
        dat_o <= {27'h0, ctrl_q};
      end else if (reg_hit(adr_i, REG_STATUS)) begin
        dat_o <= {24'h0, device_error_flags, 1'b0, link_valid, in_frame_q, !link_up_n};
      end else if (reg_hit(adr_i, REG_INT_STATUS)) begin
        dat_o <= {27'h0, int_status_q};
      end else if (reg_hit(adr_i, REG_INT_MASK)) begin
        dat_o <= {27'h0, int_mask_q};
      end else if (reg_hit(adr_i, REG_BEAT_COUNT)) begin
        dat_o <= {16'h0, beat_count_q};
      end else begin
        dat_o <= 32'h0;
      end
    end
  end

  // Beat counter wraps; any write to it clears it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      beat_count_q <= 16'h0;
    end else if (wr && reg_hit(adr_i, REG_BEAT_COUNT)) begin
      beat_count_q <= 16'h0;
    end else if (beat) begin
      beat_count_q <= beat_count_q + 16'h1;
    end
  end

  // ==========================================================
  // Interrupts, write one to clear, a new event wins
  always_comb begin
    int_set = IRQ_RESET;
    int_set[IRQ_LINK_UP] = (link_q == LINK_TRAIN) && !drop && settle_q == 4'h0;
    int_set[IRQ_LINK_DOWN] = (link_q == LINK_UP) && drop;
    int_set[IRQ_FATAL] = fatal_ev;
    int_set[IRQ_FRAME_ERR] = frame_err;
    int_set[IRQ_ERR_MSG] = err.msg_valid;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_status_q <= IRQ_RESET;
    end else if (wr && sel_i[0] && reg_hit(adr_i, REG_INT_STATUS)) begin
      int_status_q <= (int_status_q & ~dat_i[IRQ_W-1:0]) | int_set;
    end else begin
      int_status_q <= int_status_q | int_set;
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // ==========================================================
  // Checks
  a_link_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !link_up_n |-> $past(partner_ready) && !$past(flush) && !$past(channel_error))
    else $error("link up without a ready partner");
  a_train_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(link_q == LINK_TRAIN) |-> link_up_n [*4])
    else $error("link up before settle time");
  a_chan_loss: assert property (@(posedge clock) disable iff (!rst_n)
    channel_error |=> link_up_n)
    else $error("link stayed up after channel error");
  a_reset_flush: assert property (@(posedge clock) disable iff (!rst_n)
    flush |=> link_up_n && !link_valid && !in_frame_q)
    else $error("hot reset did not drop link and packets");
  a_dst_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !tx_dst_rdy_n |-> !link_up_n && (!link_valid || link_ready))
    else $error("destination ready with no room");
  a_beat_take: assert property (@(posedge clock) disable iff (!rst_n)
    (beat && !flush) |=> link_valid && link_word == $past(tx_word) && beat_count_q == $past(beat_count_q) + 16'h1
      || $past(wr))
    else $error("accepted beat not captured");
  a_no_beat: assert property (@(posedge clock) disable iff (!rst_n)
    (!beat && link_valid && !link_ready && !flush && !link_up_n) |=> link_valid && $stable(link_word))
    else $error("word changed without a beat");
  a_rem_sample: assert property (@(posedge clock) disable iff (!rst_n)
    (beat && !flush) |=> link_upper_only == ($past(tx_rem_n) && !$past(tx_eof_n)))
    else $error("remainder sampled outside final beat");
  a_cfg_internal: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_valid && rx_kind == KIND_CFG) |=> cfg_answer_valid && !app_req_valid)
    else $error("configuration request reached the application");
  a_pass_app: assert property (@(posedge clock) disable iff (!rst_n)
    (rx_valid && rx_kind inside {KIND_MSG, KIND_MEMIO, KIND_CPL}) |=> app_req_valid && app_req_kind == $past(rx_kind))
    else $error("request not passed to the application");
  a_tx_isolated: assert property (@(posedge clock) disable iff (!rst_n)
    (frame_err && !fatal_ev && !ur_ev && !correctable_error && !nonfatal_error && !(|err.clear))
      |=> device_error_flags == $past(device_error_flags))
    else $error("transmit framing error touched device flags");
endmodule

// *** tb/app_model.sv ***
`timescale 1ns/1ps
module app_model (
  // Clock
  input wire logic clock,
  // Transmit stream toward the core
  output logic [63:0] tx_word,
  output logic tx_sof_n,
  output logic tx_eof_n,
  output logic tx_rem_n,
  output logic tx_src_rdy_n,
  input wire logic tx_dst_rdy_n,
  // Inbound requests handed to the application
  input wire logic app_req_valid
);
  int unsigned beat_no = 0;
  int unsigned answered = 0;
  // Set only to provoke a framing error on purpose
  bit skip_sof = 1'b0;

  // Every forwarded request gets one reply from the application
  always @(posedge clock) begin
    if (app_req_valid === 1'h1) answered++;
  end

  initial begin
    tx_word = 64'h0;
    tx_sof_n = 1'h1;
    tx_eof_n = 1'h1;
    tx_rem_n = 1'h0;
    tx_src_rdy_n = 1'h1;
  end

  // ==========================================================
  // Packet source; call only at a rising edge
  task automatic send_pkt(input int beats, input logic rem, input int gap, output bit hung);
    int n;
    hung = 0;
    for (int i = 0; i < beats; i++) begin
      tx_word <= {32'(beat_no) ^ 32'hC0DE0000, ~32'(beat_no)};
      tx_sof_n <= (i != 0) || skip_sof;
      tx_eof_n <= (i != beats - 1);
      // Junk remainder off the last beat, the core must ignore it
      tx_rem_n <= (i == beats - 1) ? rem : beat_no[0];
      tx_src_rdy_n <= 1'h0;
      beat_no++;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (tx_dst_rdy_n !== 1'h0 && n < 200);
      if (n >= 200) hung = 1;
    end
    if (gap > 0) begin
      // Released data no longer shows the last word
      tx_src_rdy_n <= 1'h1;
      tx_sof_n <= 1'h1;
      tx_eof_n <= 1'h1;
      tx_word <= ~tx_word;
      repeat (gap) @(posedge clock);
    end
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tlp_pkg::*;
  // ==========================================================
  // Signals
  logic clock, rst_n, cyc_i, stb_i, we_i, ack_o, irq;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [63:0] tx_word, link_word;
  logic tx_sof_n, tx_eof_n, tx_rem_n, tx_src_rdy_n, tx_dst_rdy_n;
  logic link_sof, link_eof, link_upper_only, link_valid;
  logic link_ready = 1'h1;
  logic partner_ready, link_up_n, err_msg_valid, rx_valid, cfg_answer_valid, app_req_valid;
  logic [2:0] drop;
  logic [6:0] ev;
  logic [3:0] device_error_flags;
  err_msg_t err_msg_kind;
  rx_kind_t rx_kind, app_req_kind;
  int err_total = 0;
  int tests_run = 0;
  int seed = 33950;
  int stall = 0;
  int cnt;
  bit hung;
  logic [66:0] exp_q[$];
  logic [66:0] e;

  tlp_tx_stream tlp_tx_stream_inst (.clock(clock), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq(irq), .tx_word(tx_word),
    .tx_sof_n(tx_sof_n), .tx_eof_n(tx_eof_n), .tx_rem_n(tx_rem_n), .tx_src_rdy_n(tx_src_rdy_n),
    .tx_dst_rdy_n(tx_dst_rdy_n), .link_word(link_word), .link_sof(link_sof), .link_eof(link_eof),
    .link_upper_only(link_upper_only), .link_valid(link_valid), .link_ready(link_ready),
    .partner_ready(partner_ready), .channel_error(drop[0]), .hot_reset(drop[1]), .link_disable(drop[2]),
    .link_up_n(link_up_n), .training_error(ev[0]), .link_protocol_error(ev[1]), .flow_control_error(ev[2]),
    .malformed_packet(ev[3]), .receiver_overflow(ev[4]), .correctable_error(ev[5]), .nonfatal_error(ev[6]),
    .device_error_flags(device_error_flags), .err_msg_valid(err_msg_valid), .err_msg_kind(err_msg_kind),
    .rx_valid(rx_valid), .rx_kind(rx_kind), .cfg_answer_valid(cfg_answer_valid),
    .app_req_valid(app_req_valid), .app_req_kind(app_req_kind));

  app_model app_model_inst (.clock(clock), .tx_word(tx_word), .tx_sof_n(tx_sof_n), .tx_eof_n(tx_eof_n),
    .tx_rem_n(tx_rem_n), .tx_src_rdy_n(tx_src_rdy_n), .tx_dst_rdy_n(tx_dst_rdy_n),
    .app_req_valid(app_req_valid));

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= we;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    if (n >= 50) chk_bit("bus ack", 1'h1, 1'h0);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'h0, a, 32'h0);
    chk_val(what, 64'(exp), 64'(rd));
  endtask

  task automatic wait_up(output int c);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (link_up_n !== 1'h0 && c < 100);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Link sink and beat scoreboard
  always @(posedge clock) begin
    link_ready <= (stall == 0) ? 1'h1 : (stall == 1) ? 1'($random(seed)) : 1'h0;
    if (tx_src_rdy_n === 1'h0 && tx_dst_rdy_n === 1'h0) begin
      exp_q.push_back({tx_word, ~tx_sof_n, ~tx_eof_n, tx_rem_n});
    end
    if (link_valid === 1'h1 && link_ready === 1'h1) begin
      if (exp_q.size() == 0) begin
        chk_bit("link extra beat", 1'h0, 1'h1);
      end else begin
        e = exp_q.pop_front();
        chk_val("link upper", 64'(e[66:35]), 64'(link_word[63:32]));
        if (!(e[1] && e[0])) chk_val("link lower", 64'(e[34:3]), 64'(link_word[31:0]));
        chk_bit("link sof", e[2], link_sof);
        chk_bit("link eof", e[1], link_eof);
        if (e[1]) chk_bit("link upper only", e[0], link_upper_only);
      end
    end
  end

  // ==========================================================
  // Watchdog; whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("FAIL watchdog expected finish seen timeout");
    tally_and_finish;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, cyc_i, stb_i, we_i, partner_ready, rx_valid} = 6'h0;
    adr_i = 8'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    drop = 3'h0;
    ev = 7'h0;
    rx_kind = KIND_CFG;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    repeat (8) @(posedge clock);
    chk_bit("link_up_n no partner", 1'h1, link_up_n);
    chk_bit("dst_rdy_n link down", 1'h1, tx_dst_rdy_n);
    rd_chk(REG_CTRL, 32'(CTRL_RESET), "ctrl reset");
    rd_chk(REG_INT_MASK, 32'h0, "mask reset");
    wb(1'h1, 8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h0, "unmapped read");
    partner_ready <= 1'h1;
    wait_up(cnt);
    chk_val("link up delay", 64'(LINK_SETTLE_CYC + 2), 64'(cnt));
    rd_chk(REG_INT_STATUS, 32'(1 << IRQ_LINK_UP), "int status");
    chk_bit("irq masked", 1'h0, irq);
    wb(1'h1, REG_INT_MASK, 32'h1F);
    @(posedge clock);
    chk_bit("irq unmasked", 1'h1, irq);
    wb(1'h1, REG_INT_STATUS, 32'h1F);
    @(posedge clock);
    chk_bit("irq cleared", 1'h0, irq);
    // Random packets with a stalling link, some back to back
    stall = 1;
    for (int p = 0; p < 24; p++) begin
      app_model_inst.send_pkt(1 + int'($unsigned($random(seed)) % 4), 1'($random(seed)),
                              (p == 23) ? 1 : int'($unsigned($random(seed)) % 3), hung);
      if (hung) chk_bit("tx accepted", 1'h1, 1'h0);
    end
    stall = 0;
    repeat (20) @(posedge clock);
    chk_val("beats left", 64'h0, 64'(exp_q.size()));
    rd_chk(REG_BEAT_COUNT, 32'(app_model_inst.beat_no), "beat count");
    chk_val("flags after tx", 64'h0, 64'(device_error_flags));
    // Packet without a start marker: interrupt only
    app_model_inst.skip_sof = 1'b1;
    app_model_inst.send_pkt(1, 1'h0, 1, hung);
    app_model_inst.skip_sof = 1'b0;
    repeat (2) @(posedge clock);
    chk_val("flags after frame error", 64'h0, 64'(device_error_flags));
    rd_chk(REG_INT_STATUS, 32'(1 << IRQ_FRAME_ERR), "frame error irq");
    // Fatal sources reported, then correctable and non-fatal unreported
    wb(1'h1, REG_CTRL, 32'h04);
    for (int i = 0; i < 7; i++) begin
      if (i == 5) wb(1'h1, REG_CTRL, 32'h0);
      ev[i] <= 1'h1;
      @(posedge clock);
      ev[i] <= 1'h0;
      @(posedge clock);
      chk_bit("msg valid", i < 5, err_msg_valid);
      if (i < 5) chk_val("msg kind", 64'(MSG_FATAL), 64'(err_msg_kind));
      chk_bit("error flag", 1'h1, device_error_flags[(i < 5) ? FLAG_FATAL : i - 5]);
      wb(1'h1, REG_STATUS, 32'hF0);
    end
    rd_chk(REG_STATUS, 32'(1 << STAT_LINK_UP), "status idle");
    // Inbound routing, then a ROM request with the ROM disabled and an unknown kind
    wb(1'h1, REG_CTRL, 32'h10);
    for (int k = 0; k < 7; k++) begin
      if (k == 5) wb(1'h1, REG_CTRL, 32'h0);
      if (k == 6) wb(1'h1, REG_STATUS, 32'hF0);
      rx_kind <= (k == 6) ? rx_kind_t'(3'h7) : (k == 5) ? KIND_ROM : rx_kind_t'(k);
      rx_valid <= 1'h1;
      @(posedge clock);
      rx_valid <= 1'h0;
      @(posedge clock);
      chk_bit("cfg answered", k == 0, cfg_answer_valid);
      chk_bit("app request", k > 0 && k < 5, app_req_valid);
      if (k > 0 && k < 5) chk_val("app kind", 64'(k), 64'(app_req_kind));
      chk_bit("ur flag", k >= 5, device_error_flags[FLAG_UR]);
    end
    chk_val("requests answered", 64'h4, 64'(app_model_inst.answered));
    wb(1'h1, REG_INT_STATUS, 32'h1F);
    // Channel error, hot reset and link disable; last two with a held word
    for (int c = 0; c < 3; c++) begin
      if (c > 0) begin
        stall = 2;
        repeat (2) @(posedge clock);
        app_model_inst.send_pkt(1, 1'h0, 2, hung);
        chk_bit("stage held", 1'h1, link_valid);
      end
      drop[c] <= 1'h1;
      @(posedge clock);
      if (c > 0) chk_bit("dst_rdy_n in drop", 1'h1, tx_dst_rdy_n);
      drop[c] <= 1'h0;
      @(posedge clock);
      chk_bit("link_up_n after drop", 1'h1, link_up_n);
      if (c > 0) chk_bit("stage flushed", 1'h0, link_valid);
      exp_q.delete();
      stall = 0;
      wait_up(cnt);
      chk_bit("relinked", 1'h0, link_up_n);
    end
    rd_chk(REG_INT_STATUS, 32'((1 << IRQ_LINK_UP) | (1 << IRQ_LINK_DOWN)), "int after drops");
    chk_bit("irq on link down", 1'h1, irq);
    wb(1'h1, REG_INT_STATUS, 32'h1F);
    @(posedge clock);
    chk_bit("irq idle", 1'h0, irq);
    tally_and_finish;
  end
endmodule
